// *** core/spp_defines.svh ***
// Constants of the sector and password protection block: offsets, fields, resets, timing.
// Assumes inclusion by bare name from every file that needs these values.
`ifndef SPP_DEFINES_SVH
`define SPP_DEFINES_SVH

`define SPP_CFG_WIDTH       16
`define SPP_CFG_RESET       16'hFFFF
`define SPP_CFG_PWD_BIT     2
`define SPP_CFG_SECT_BIT    1
`define SPP_FREEZE_RESET    1'h1
`define SPP_PWD_WIDTH       64
`define SPP_PWD_FACTORY     64'hFFFFFFFFFFFFFFFF
`define SPP_NUM_SECTORS     4096
`define SPP_NUM_SUBSECTORS  16
`define SPP_NV_UNLOCKED     1'h1
`define SPP_VL_UNLOCKED     1'h0
`define SPP_RSP_LATENCY     2

`endif

// *** core/spp_pkg.sv ***
// Types shared by the sector and password protection block.
// Assumes nothing beyond a SystemVerilog compiler.
package spp_pkg;

  typedef enum logic [3:0] {
    SPP_OP_RD_CFG,
    SPP_OP_WR_CFG,
    SPP_OP_RD_PWD,
    SPP_OP_WR_PWD,
    SPP_OP_UNLOCK_PWD,
    SPP_OP_RD_FREEZE,
    SPP_OP_WR_FREEZE,
    SPP_OP_RD_NV_LOCK,
    SPP_OP_WR_NV_LOCK,
    SPP_OP_ER_NV_LOCK,
    SPP_OP_RD_VL_LOCK,
    SPP_OP_WR_VL_LOCK,
    SPP_OP_CHK_PROT
  } spp_op_t;

  typedef enum {
    SPP_ST_IDLE,
    SPP_ST_EXEC
  } spp_state_t;

endpackage

// *** core/spp_lock_array.sv ***
// One bit per entry lock storage with a registered read port and a clear of all entries.
// Assumes a single clock; clear and write never target the same entry in one cycle usefully.
`timescale 1ns/10ps
module spp_lock_array #(
  parameter int   DEPTH   = 4096,
  parameter int   AW      = 12,
  parameter logic CLR_VAL = 1'h1
) (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          reset,
  // Clear of every entry
  input  wire logic          clr,
  // Write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic          wr_bit,
  // Read port
  input  wire logic [AW-1:0] rd_addr,
  output logic               rd_bit
);

  logic mem_ff [DEPTH];

  // Clear wins over a write, so an erase never leaves a stray entry behind.
  always_ff @(posedge clk_sys) begin
    if (clr) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= CLR_VAL;
      end
    end else if (wr_en) begin
      mem_ff[wr_addr] <= wr_bit;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rd_bit <= CLR_VAL;
    end else begin
      rd_bit <= mem_ff[rd_addr];
    end
  end

endmodule

// *** core/spp_top.sv ***
// Sector and password protection logic of a serial flash, behind its command decoder.
// Assumes the decoder hands over one command at a time on cmd_* and reads rsp_* back.
//
// Notes on behaviour
// - A 16-bit nonvolatile protection word; only bits 2 and 1 work, rest read one.
// - One volatile freeze bit guards every nonvolatile lock bit against change.
// - Each sector has a nonvolatile lock bit that persists until erased back to one.
// - Each sector has a volatile lock bit lost on reset or power loss.
// - First and last sectors lock volatilely per 4KB subsector, nonvolatilely as whole.
// - Bit 2 zero turns password protection on forever; password then hidden and fixed.
// - Bit 1 zero keeps bit 2 at one, disabling password protection for good.
// - Bits 2 and 1 are one-time programmable; at most one ever reaches zero.
// - Host sets password before clearing bit 2; afterwards password changes are refused.
// - With password protection on, freeze goes zero to one only with correct password.
// - Wrong password leaves the freeze bit unchanged.
// - Nonvolatile lock bits are programmable whatever bit 1 holds, subject to freeze.
// - As shipped, every sector is unlocked.
// - Freeze defaults to one; at zero, program and erase of nonvolatile locks refused.
// - The freeze read command returns the current freeze bit.
// - With password protection on, reset and power-up force freeze to zero.
// - Unlock with correct password sets freeze to one.
// - The freeze write command clears freeze to zero.
// - Nonvolatile lock zero locks, one unlocks; erase returns all of them to one.
// - Volatile lock one blocks its sector; all volatile locks are zero after reset.
`timescale 1ns/10ps
`include "spp_defines.svh"
module spp_top #(
  parameter int NUM_SECTORS = `SPP_NUM_SECTORS,
  parameter int SW          = $clog2(`SPP_NUM_SECTORS)
) (
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       reset,
  // Return of all nonvolatile state to its as-shipped contents
  input  wire logic                       factory_init,
  // Command request
  input  wire logic                       cmd_valid,
  output logic                            cmd_ready,
  input  spp_pkg::spp_op_t                cmd_op,
  input  wire logic [SW-1:0]              cmd_sector,
  input  wire logic [3:0]                 cmd_subsector,
  input  wire logic [`SPP_PWD_WIDTH-1:0]  cmd_wdata,
  // Command answer
  output logic                            rsp_valid,
  output logic [`SPP_PWD_WIDTH-1:0]       rsp_data,
  output logic                            rsp_err,
  // Status levels
  output logic                            freeze_bit,
  output logic                            pwd_prot_on
);

  import spp_pkg::*;

  localparam logic [SW-1:0] LAST_SECTOR = SW'(NUM_SECTORS - 1);

  spp_state_t                   state_ff;
  spp_op_t                      op_ff;
  logic [SW-1:0]                sector_ff;
  logic [3:0]                   sub_ff;
  logic [`SPP_PWD_WIDTH-1:0]    wdata_ff;
  logic [`SPP_CFG_WIDTH-1:0]    cfg_ff;
  logic [`SPP_PWD_WIDTH-1:0]    pwd_ff;
  logic                         freeze_ff;
  logic                         rsp_valid_ff;
  logic [`SPP_PWD_WIDTH-1:0]    rsp_data_ff;
  logic                         rsp_err_ff;

  logic                         take;
  logic                         exec;
  logic                         nv_rd;
  logic                         vl_rd;
  logic                         is_edge;
  logic                         edge_idx;
  logic                         vl_bit;
  logic                         pwd_on;
  logic                         sect_lock_set;
  logic                         cfg_ok;
  logic [`SPP_CFG_WIDTH-1:0]    nxt_cfg;
  logic                         pwd_match;
  logic                         nv_wr_en;
  logic                         nv_clr;
  logic                         vl_wr_en;
  logic                         nxt_err;
  logic [`SPP_PWD_WIDTH-1:0]    nxt_data;
  logic                         sub_lo_rd;
  logic                         sub_hi_rd;
  logic                         vl_clr;
  logic                         vl_wr_sect;
  logic                         vl_wr_lo;
  logic                         vl_wr_hi;
  logic                         sect_prot;
  logic                         freeze_rst_val;
  logic                         ex_wr_cfg;
  logic                         ex_wr_pwd;
  logic                         ex_unlock;
  logic                         ex_wr_freeze;
  logic                         ex_wr_nv;
  logic                         ex_er_nv;
  logic                         ex_wr_vl;

  assign take      = cmd_valid && (state_ff == SPP_ST_IDLE);
  assign exec      = (state_ff == SPP_ST_EXEC);
  assign cmd_ready = (state_ff == SPP_ST_IDLE);

  assign pwd_on        = !cfg_ff[`SPP_CFG_PWD_BIT];
  assign sect_lock_set = !cfg_ff[`SPP_CFG_SECT_BIT];
  assign pwd_match     = (wdata_ff == pwd_ff);

  assign is_edge  = (sector_ff == '0) || (sector_ff == LAST_SECTOR);
  assign edge_idx = (sector_ff != '0);
  assign vl_bit   = is_edge ? (edge_idx ? sub_hi_rd : sub_lo_rd) : vl_rd;
  assign sect_prot = !nv_rd || vl_bit;

  // Decoding each state-changing command once keeps the register blocks below short.
  assign ex_wr_cfg    = exec && (op_ff == SPP_OP_WR_CFG);
  assign ex_wr_pwd    = exec && (op_ff == SPP_OP_WR_PWD);
  assign ex_unlock    = exec && (op_ff == SPP_OP_UNLOCK_PWD);
  assign ex_wr_freeze = exec && (op_ff == SPP_OP_WR_FREEZE);
  assign ex_wr_nv     = exec && (op_ff == SPP_OP_WR_NV_LOCK);
  assign ex_er_nv     = exec && (op_ff == SPP_OP_ER_NV_LOCK);
  assign ex_wr_vl     = exec && (op_ff == SPP_OP_WR_VL_LOCK);

  // The sequencer takes one command, executes it for one cycle, then answers.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_ff <= SPP_ST_IDLE;
    end else begin
      case (state_ff)
        SPP_ST_IDLE: begin
          if (take) begin
            state_ff <= SPP_ST_EXEC;
          end
        end
        SPP_ST_EXEC: begin
          state_ff <= SPP_ST_IDLE;
        end
        default: begin
          state_ff <= SPP_ST_IDLE;
        end
      endcase
    end
  end

  // Arguments are captured at the take edge so the host may move on during execution.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      op_ff     <= SPP_OP_RD_CFG;
      sector_ff <= '0;
      sub_ff    <= 4'h0;
      wdata_ff  <= '0;
    end else if (take) begin
      op_ff     <= cmd_op;
      sector_ff <= cmd_sector;
      sub_ff    <= cmd_subsector;
      wdata_ff  <= cmd_wdata;
    end
  end

  // Programming only pulls bits to zero; reserved bits are kept at one.
  always_comb begin
    nxt_cfg = `SPP_CFG_RESET;
    nxt_cfg[`SPP_CFG_PWD_BIT]  = cfg_ff[`SPP_CFG_PWD_BIT] & wdata_ff[`SPP_CFG_PWD_BIT];
    nxt_cfg[`SPP_CFG_SECT_BIT] = cfg_ff[`SPP_CFG_SECT_BIT] & wdata_ff[`SPP_CFG_SECT_BIT];
    cfg_ok = !(!nxt_cfg[`SPP_CFG_PWD_BIT] && !nxt_cfg[`SPP_CFG_SECT_BIT]);
    if (sect_lock_set && !nxt_cfg[`SPP_CFG_PWD_BIT]) begin
      cfg_ok = 1'b0;
    end
  end

  // Nonvolatile contents are untouched by reset; only factory_init restores them.
  always_ff @(posedge clk_sys) begin
    if (factory_init) begin
      cfg_ff <= `SPP_CFG_RESET;
    end else if (ex_wr_cfg && cfg_ok) begin
      cfg_ff <= nxt_cfg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (factory_init) begin
      pwd_ff <= `SPP_PWD_FACTORY;
    end else if (ex_wr_pwd && !pwd_on) begin
      pwd_ff <= wdata_ff;
    end
  end

  // A sync reset may look at the stored word, so the locked state follows it.
  assign freeze_rst_val = (pwd_on && !factory_init) ? 1'b0 : `SPP_FREEZE_RESET;

  always_ff @(posedge clk_sys) begin
    if (reset || factory_init) begin
      freeze_ff <= freeze_rst_val;
    end else if (ex_wr_freeze) begin
      freeze_ff <= 1'b0;
    end else if (ex_unlock && (!pwd_on || pwd_match)) begin
      freeze_ff <= 1'b1;
    end
  end

  // Wrong password falls through the branch above and the freeze bit stays.

  assign nv_wr_en   = ex_wr_nv && freeze_ff;
  assign nv_clr     = factory_init || (ex_er_nv && freeze_ff);
  assign vl_wr_en   = ex_wr_vl;
  assign vl_clr     = reset || factory_init;
  assign vl_wr_sect = vl_wr_en && !is_edge;
  assign vl_wr_lo   = vl_wr_en && is_edge && !edge_idx;
  assign vl_wr_hi   = vl_wr_en && is_edge && edge_idx;

  spp_lock_array #(
    .DEPTH   (NUM_SECTORS),
    .AW      (SW),
    .CLR_VAL (`SPP_NV_UNLOCKED)
  ) u_nv_locks (
    .clk_sys (clk_sys),
    .reset   (reset),
    .clr     (nv_clr),
    .wr_en   (nv_wr_en),
    .wr_addr (sector_ff),
    .wr_bit  (1'b0),
    .rd_addr (cmd_sector),
    .rd_bit  (nv_rd)
  );

  spp_lock_array #(
    .DEPTH   (NUM_SECTORS),
    .AW      (SW),
    .CLR_VAL (`SPP_VL_UNLOCKED)
  ) u_vl_locks (
    .clk_sys (clk_sys),
    .reset   (reset),
    .clr     (vl_clr),
    .wr_en   (vl_wr_sect),
    .wr_addr (sector_ff),
    .wr_bit  (wdata_ff[0]),
    .rd_addr (cmd_sector),
    .rd_bit  (vl_rd)
  );

  // The two edge sectors keep one volatile bit per subsector in arrays of their own.
  spp_lock_array #(
    .DEPTH   (`SPP_NUM_SUBSECTORS),
    .AW      ($clog2(`SPP_NUM_SUBSECTORS)),
    .CLR_VAL (`SPP_VL_UNLOCKED)
  ) u_sub_lo_locks (
    .clk_sys (clk_sys),
    .reset   (reset),
    .clr     (vl_clr),
    .wr_en   (vl_wr_lo),
    .wr_addr (sub_ff),
    .wr_bit  (wdata_ff[0]),
    .rd_addr (cmd_subsector),
    .rd_bit  (sub_lo_rd)
  );

  spp_lock_array #(
    .DEPTH   (`SPP_NUM_SUBSECTORS),
    .AW      ($clog2(`SPP_NUM_SUBSECTORS)),
    .CLR_VAL (`SPP_VL_UNLOCKED)
  ) u_sub_hi_locks (
    .clk_sys (clk_sys),
    .reset   (reset),
    .clr     (vl_clr),
    .wr_en   (vl_wr_hi),
    .wr_addr (sub_ff),
    .wr_bit  (wdata_ff[0]),
    .rd_addr (cmd_subsector),
    .rd_bit  (sub_hi_rd)
  );

  always_comb begin
    nxt_err  = 1'b0;
    nxt_data = '0;
    case (op_ff)
      SPP_OP_RD_CFG: begin
        nxt_data = {{(`SPP_PWD_WIDTH - `SPP_CFG_WIDTH){1'b0}}, cfg_ff};
      end
      SPP_OP_WR_CFG: begin
        nxt_err = !cfg_ok;
      end
      SPP_OP_RD_PWD: begin
        nxt_err  = pwd_on;
        nxt_data = pwd_on ? '0 : pwd_ff;
      end
      SPP_OP_WR_PWD: begin
        nxt_err = pwd_on;
      end
      SPP_OP_UNLOCK_PWD: begin
        nxt_err = pwd_on && !pwd_match;
      end
      SPP_OP_RD_FREEZE: begin
        nxt_data[0] = freeze_ff;
      end
      SPP_OP_WR_FREEZE: begin
        nxt_err = 1'b0;
      end
      SPP_OP_RD_NV_LOCK: begin
        nxt_data[0] = nv_rd;
      end
      SPP_OP_WR_NV_LOCK, SPP_OP_ER_NV_LOCK: begin
        nxt_err = !freeze_ff;
      end
      SPP_OP_RD_VL_LOCK: begin
        nxt_data[0] = vl_bit;
      end
      SPP_OP_WR_VL_LOCK: begin
        nxt_err = 1'b0;
      end
      SPP_OP_CHK_PROT: begin
        nxt_data[0] = sect_prot;
        nxt_err     = sect_prot;
      end
      default: begin
        nxt_err = 1'b1;
      end
    endcase
  end

  // Answers are registered, so data and error hold until the next answer.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rsp_valid_ff <= 1'b0;
      rsp_data_ff  <= '0;
      rsp_err_ff   <= 1'b0;
    end else begin
      rsp_valid_ff <= exec;
      if (exec) begin
        rsp_data_ff <= nxt_data;
        rsp_err_ff  <= nxt_err;
      end
    end
  end

  assign rsp_valid   = rsp_valid_ff;
  assign rsp_data    = rsp_data_ff;
  assign rsp_err     = rsp_err_ff;
  assign freeze_bit  = freeze_ff;
  assign pwd_prot_on = pwd_on;

endmodule

// *** sim/spp_host_model.sv ***
// Host controller model that issues one command at a time to the protection block.
// Assumes the bench calls issue and idle from just after a rising clock edge.
`timescale 1ns/10ps
module spp_host_model (
  // Clock
  input  wire logic       clk_sys,
  // Command request
  output logic            cmd_valid,
  input  wire logic       cmd_ready,
  output spp_pkg::spp_op_t cmd_op,
  output logic [3:0]      cmd_sector,
  output logic [3:0]      cmd_subsector,
  output logic [63:0]     cmd_wdata
);
  import spp_pkg::*;

  initial begin
    cmd_valid = 1'h0;
    cmd_op = SPP_OP_RD_CFG;
    cmd_sector = 4'h0;
    cmd_subsector = 4'h0;
    cmd_wdata = 64'h0;
  end

  // Valid stays high between back-to-back commands so no signal is assigned twice in a step.
  task automatic issue(input spp_op_t op, input logic [3:0] s, sub, input logic [63:0] wd,
                       output bit ok);
    ok = 1'b0;
    cmd_valid = 1'h1;
    cmd_op = op;
    cmd_sector = s;
    cmd_subsector = sub;
    cmd_wdata = wd;
    for (int i = 0; i < 20 && !ok; i++) begin
      ok = (cmd_ready === 1'b1);
      @(posedge clk_sys);
      #1;
    end
  endtask

  // On release the sector and write data lines are inverted so a stale value is never mistaken for data.
  task idle;
    cmd_valid = 1'h0;
    cmd_sector = ~cmd_sector;
    cmd_wdata = ~cmd_wdata;
  endtask
endmodule

// *** sim/spp_top_checker.sv ***
// Concurrent checks on the ports of the protection block.
// Assumes one clock and the two-cycle answer of the command port.
`timescale 1ns/10ps
module spp_top_checker (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic       factory_init,
  // Command and answer
  input wire logic       cmd_valid,
  input wire logic       cmd_ready,
  input spp_pkg::spp_op_t cmd_op,
  input wire logic       rsp_valid,
  input wire logic       rsp_err,
  // Status
  input wire logic       freeze_bit,
  input wire logic       pwd_prot_on
);
  import spp_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic take;
  logic unlock_ff;
  assign take = cmd_valid && cmd_ready;
  always_ff @(posedge clk_sys) begin
    unlock_ff <= take && cmd_op == SPP_OP_UNLOCK_PWD;
  end
  sequence answer_s; !rsp_valid ##1 rsp_valid; endsequence
  sequence busy_s; !cmd_ready ##1 cmd_ready; endsequence

  rsp_timing_a: assert property (take |=> answer_s) else $error("answer late");
  busy_slot_a: assert property (take |=> busy_s) else $error("ready wrong");
  rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid) else $error("answer long");
  freeze_clear_a: assert property (take && cmd_op == SPP_OP_WR_FREEZE |-> ##2 !freeze_bit)
    else $error("freeze not cleared");
  nv_refuse_a: assert property (take && !freeze_bit && (cmd_op == SPP_OP_WR_NV_LOCK ||
    cmd_op == SPP_OP_ER_NV_LOCK) |-> ##2 rsp_err) else $error("lock change accepted");
  pwd_hide_a: assert property (take && pwd_prot_on && (cmd_op == SPP_OP_WR_PWD ||
    cmd_op == SPP_OP_RD_PWD) |-> ##2 rsp_err) else $error("password reachable");
  freeze_hold_a: assert property (!freeze_bit && pwd_prot_on && !factory_init &&
    !unlock_ff |=> !freeze_bit) else $error("freeze opened");
  reset_lock_a: assert property (disable iff (1'b0)
    reset && !factory_init && pwd_prot_on |=> !freeze_bit) else $error("freeze open at reset");
  prot_keep_a: assert property (pwd_prot_on && !factory_init |=> pwd_prot_on)
    else $error("password protection dropped");
  unlock_open_a: assert property (take && cmd_op == SPP_OP_UNLOCK_PWD && !pwd_prot_on
    |-> ##2 freeze_bit) else $error("unlock failed");
endmodule

bind spp_top spp_top_checker i_spp_top_checker (.clk_sys(clk_sys), .reset(reset),
  .factory_init(factory_init), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd_op(cmd_op), .rsp_valid(rsp_valid), .rsp_err(rsp_err), .freeze_bit(freeze_bit),
  .pwd_prot_on(pwd_prot_on));

// *** sim/spp_top_tb_top.sv ***
// Self-checking bench of the protection block with sixteen sectors.
// Assumes the host model and the checker compile before it.
`timescale 1ns/10ps
module spp_top_tb_top;
  import spp_pkg::*;
  logic clk_sys = 1'h0, reset = 1'h1, factory_init = 1'h1;
  logic cmd_valid, cmd_ready, rsp_valid, rsp_err, freeze_bit, pwd_prot_on;
  spp_op_t cmd_op;
  logic [3:0] cmd_sector, cmd_subsector, sa, sb;
  logic [63:0] cmd_wdata, rsp_data, pw;
  logic [65:0] notes[$];
  int err_count = 0, num_checks = 0;

  always #50 clk_sys = ~clk_sys;

  spp_top #(.NUM_SECTORS(16), .SW(4)) i_spp_top (.clk_sys(clk_sys), .reset(reset),
    .factory_init(factory_init), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_sector(cmd_sector), .cmd_subsector(cmd_subsector),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err),
    .freeze_bit(freeze_bit), .pwd_prot_on(pwd_prot_on));
  spp_host_model i_spp_host_model (.clk_sys(clk_sys), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_sector(cmd_sector),
    .cmd_subsector(cmd_subsector), .cmd_wdata(cmd_wdata));

  task give_verdict;
    chk(65'(notes.size()), 65'h0);
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task chk(input logic [64:0] seen, input logic [64:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Each note holds a data-compare flag, the error bit and the data.
  always @(posedge clk_sys) begin
    if (rsp_valid === 1'b1) begin
      if (notes.size() == 0) chk(65'(rsp_valid), 65'h0);
      else begin
        chk({rsp_err, notes[0][65] ? rsp_data : notes[0][63:0]}, notes[0][64:0]);
        void'(notes.pop_front());
      end
    end
  end

  task req(spp_op_t op, logic [3:0] s, sub, logic [63:0] wd, logic e, logic [63:0] d, logic m);
    bit ok;
    notes.push_back({m, e, m ? d : 64'h0});
    i_spp_host_model.issue(op, s, sub, wd, ok);
    if (!ok) begin
      err_count++;
      give_verdict;
    end
  endtask

  task settle;
    i_spp_host_model.idle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  initial begin
    void'($urandom(84347));
    sa = 4'(($urandom % 13) + 1);
    sb = sa + 4'h1;
    pw = {$urandom, $urandom};
    repeat (10) @(posedge clk_sys);
    #1;
    reset = 1'h0;
    factory_init = 1'h0;
    req(SPP_OP_RD_CFG, 4'h0, 4'h0, 64'h0, 1'h0, 64'hFFFF, 1'h1);
    req(SPP_OP_RD_FREEZE, 4'h0, 4'h0, 64'h0, 1'h0, 64'h1, 1'h1);
    req(SPP_OP_CHK_PROT, sa, 4'h0, 64'h0, 1'h0, 64'h0, 1'h0);
    req(SPP_OP_WR_NV_LOCK, sa, 4'h0, 64'h0, 1'h0, 64'h0, 1'h0);
    req(SPP_OP_RD_NV_LOCK, sa, 4'h0, 64'h0, 1'h0, 64'h0, 1'h1);
    req(SPP_OP_CHK_PROT, sa, 4'h0, 64'h0, 1'h1, 64'h0, 1'h0);
    req(SPP_OP_WR_VL_LOCK, sb, 4'h0, 64'h1, 1'h0, 64'h0, 1'h0);
    req(SPP_OP_CHK_PROT, sb, 4'h0, 64'h0, 1'h1, 64'h0, 1'h0);
    req(SPP_OP_WR_VL_LOCK, 4'h0, 4'h2, 64'h1, 1'h0, 64'h0, 1'h0);
    req(SPP_OP_CHK_PROT, 4'h0, 4'h3, 64'h0, 1'h0, 64'h0, 1'h0);
    req(SPP_OP_CHK_PROT, 4'h0, 4'h2, 64'h0, 1'h1, 64'h0, 1'h0);
    req(SPP_OP_RD_VL_LOCK, 4'h0, 4'h2, 64'h0, 1'h0, 64'h1, 1'h1);
    req(SPP_OP_WR_VL_LOCK, 4'hF, 4'h5, 64'h1, 1'h0, 64'h0, 1'h0);
    req(SPP_OP_RD_VL_LOCK, 4'hF, 4'h2, 64'h0, 1'h0, 64'h0, 1'h1);
    req(SPP_OP_CHK_PROT, 4'hF, 4'h5, 64'h0, 1'h1, 64'h0, 1'h0);
    req(SPP_OP_WR_FREEZE, 4'h0, 4'h0, 64'h0, 1'h0, 64'h0, 1'h0);
    req(SPP_OP_WR_NV_LOCK, sb, 4'h0, 64'h0, 1'h1, 64'h0, 1'h0);
    req(SPP_OP_ER_NV_LOCK, 4'h0, 4'h0, 64'h0, 1'h1, 64'h0, 1'h0);
    req(SPP_OP_RD_FREEZE, 4'h0, 4'h0, 64'h0, 1'h0, 64'h0, 1'h1);
    req(SPP_OP_UNLOCK_PWD, 4'h0, 4'h0, 64'h0, 1'h0, 64'h0, 1'h0);
    req(SPP_OP_ER_NV_LOCK, 4'h0, 4'h0, 64'h0, 1'h0, 64'h0, 1'h0);
    req(SPP_OP_RD_NV_LOCK, sa, 4'h0, 64'h0, 1'h0, 64'h1, 1'h1);
    req(SPP_OP_WR_PWD, 4'h0, 4'h0, pw, 1'h0, 64'h0, 1'h0);
    req(SPP_OP_RD_PWD, 4'h0, 4'h0, 64'h0, 1'h0, pw, 1'h1);
    req(SPP_OP_WR_CFG, 4'h0, 4'h0, 64'hFFFB, 1'h0, 64'h0, 1'h0);
    req(SPP_OP_RD_CFG, 4'h0, 4'h0, 64'h0, 1'h0, 64'hFFFB, 1'h1);
    req(SPP_OP_WR_CFG, 4'h0, 4'h0, 64'hFFFD, 1'h1, 64'h0, 1'h0);
    req(SPP_OP_RD_PWD, 4'h0, 4'h0, 64'h0, 1'h1, 64'h0, 1'h1);
    req(SPP_OP_WR_PWD, 4'h0, 4'h0, ~pw, 1'h1, 64'h0, 1'h0);
    settle;
    chk(65'(pwd_prot_on), 65'h1);
    reset = 1'h1;
    @(posedge clk_sys);
    #1;
    reset = 1'h0;
    chk(65'(freeze_bit), 65'h0);
    req(SPP_OP_CHK_PROT, sb, 4'h0, 64'h0, 1'h0, 64'h0, 1'h0);
    req(SPP_OP_RD_VL_LOCK, 4'h0, 4'h2, 64'h0, 1'h0, 64'h0, 1'h1);
    req(SPP_OP_RD_VL_LOCK, 4'hF, 4'h5, 64'h0, 1'h0, 64'h0, 1'h1);
    req(SPP_OP_UNLOCK_PWD, 4'h0, 4'h0, ~pw, 1'h1, 64'h0, 1'h0);
    req(SPP_OP_RD_FREEZE, 4'h0, 4'h0, 64'h0, 1'h0, 64'h0, 1'h1);
    req(SPP_OP_UNLOCK_PWD, 4'h0, 4'h0, pw, 1'h0, 64'h0, 1'h0);
    req(SPP_OP_RD_FREEZE, 4'h0, 4'h0, 64'h0, 1'h0, 64'h1, 1'h1);
    settle;
    give_verdict;
  end
endmodule
